// *** logic/port_six_pkg.sv ***
package port_six_pkg;

	// ****************************************************************
	// Register map (byte addresses, word aligned)
	// ****************************************************************
	localparam logic [3:0] OFS_DIRECTION = 4'h0;
	localparam logic [3:0] OFS_LATCH = 4'h4;
	localparam logic [3:0] OFS_CONTROL = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	localparam logic [7:0] LATCH_RESET = 8'h80;
	localparam logic [7:0] DIRECTION_RESET = 8'h80;
	localparam logic [7:0] DIRECTION_READ = 8'hff;
	localparam logic [6:0] PIN_MASK = 7'h7f;
	localparam logic [7:0] AREA_ALL_ONES = 8'hff;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	// Control register fields
	localparam int CTL_BUS_RELEASE_ENABLE_BIT = 0;
	localparam int CTL_WAITMODE_BIT = 1;
	localparam int CTL_AREA_LSB = 8;
	localparam logic [15:0] CONTROL_RESET = 16'hff00;

	// Pin positions
	localparam int PIN_WAIT = 0;
	localparam int PIN_BUS_RELEASE_REQUEST = 1;
	localparam int PIN_BACK = 2;
	localparam int PIN_ADDR = 3;
	localparam int PIN_READ = 4;
	localparam int PIN_HIGH = 5;
	localparam int PIN_LOW = 6;

	typedef enum logic [1:0]
	{
		MODE_RUN,
		MODE_SW_STANDBY,
		MODE_HW_STANDBY
	} power_mode_t;

	// Bus control signals from and to the bus controller (active low strobes)
	typedef struct packed
	{
		logic low_byte_write_strobe_n;
		logic high_byte_write_strobe_n;
		logic read_strobe_n;
		logic address_strobe_n;
		logic bus_release_ack_n;
	} bus_ctl_out_t;

	typedef struct packed
	{
		logic bus_release_request_n;
		logic wait_n;
	} bus_ctl_in_t;

	typedef struct packed
	{
		logic [6:0] out;
		logic [6:0] oe_n;
	} pin_drive_t;

endpackage

// *** logic/port_six_pin_mux.sv ***
`timescale 1ns/1ps
module port_six_pin_mux
(
	// Mode and control
	input wire logic expanded_mode,
	input wire logic bus_release_enable,
	input wire logic wait_active,
	// Port registers
	input wire logic [6:0] port_six_output_latch,
	input wire logic [6:0] port_six_direction_bits,
	// Bus control functions
	input wire port_six_pkg::bus_ctl_out_t ctl_out,
	// Pin drive
	output port_six_pkg::pin_drive_t drive,
	output logic [6:0] function_owned
);
	import port_six_pkg::*;

	always_comb
	begin
		logic [6:0] f_out;
		f_out = '0;
		function_owned = '0;
		if (expanded_mode)
		begin
			function_owned[PIN_LOW] = 1'b1;
			function_owned[PIN_HIGH] = 1'b1;
			function_owned[PIN_READ] = 1'b1;
			function_owned[PIN_ADDR] = 1'b1;
			function_owned[PIN_BACK] = bus_release_enable;
			function_owned[PIN_BUS_RELEASE_REQUEST] = bus_release_enable;
			function_owned[PIN_WAIT] = wait_active;
		end
		f_out[PIN_LOW] = ctl_out.low_byte_write_strobe_n;
		f_out[PIN_HIGH] = ctl_out.high_byte_write_strobe_n;
		f_out[PIN_READ] = ctl_out.read_strobe_n;
		f_out[PIN_ADDR] = ctl_out.address_strobe_n;
		f_out[PIN_BACK] = ctl_out.bus_release_ack_n;
		for (int i = 0; i < 7; i++)
		begin
			if (function_owned[i])
			begin
				// Request and wait are inputs; strobes and acknowledge drive
				drive.out[i] = f_out[i];
				drive.oe_n[i] = (i == PIN_BUS_RELEASE_REQUEST || i == PIN_WAIT);
			end
			else
			begin
				drive.out[i] = port_six_output_latch[i];
				drive.oe_n[i] = ~port_six_direction_bits[i];
			end
		end
	end

endmodule

// *** logic/port_six.sv ***
`timescale 1ns/1ps
module port_six
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Operating state
	input wire logic expanded_mode,
	input wire port_six_pkg::power_mode_t power_mode,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Bus controller side
	input wire port_six_pkg::bus_ctl_out_t ctl_out,
	output port_six_pkg::bus_ctl_in_t ctl_in,
	// Pins
	input wire logic [6:0] pin_in,
	output logic [6:0] pin_out,
	output logic [6:0] pin_oe_n
);
	import port_six_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] latch_reg, latch_next;
	logic [7:0] dir_reg, dir_next;
	logic [15:0] ctl_reg, ctl_next;
	logic [31:0] readdata_reg, readdata_next;
	logic ack_reg, ack_next;
	logic hw_standby;
	logic bus_release_enable;
	logic wait_active;
	logic [6:0] function_owned;
	pin_drive_t drive;

	assign hw_standby = (power_mode == MODE_HW_STANDBY);
	assign bus_release_enable = ctl_reg[CTL_BUS_RELEASE_ENABLE_BIT];
	assign wait_active = ctl_reg[CTL_WAITMODE_BIT]
		|| (ctl_reg[CTL_AREA_LSB +: 8] != AREA_ALL_ONES);

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] val,
		input logic en);
		merge_byte = en ? val : old;
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	always_comb
	begin
		logic access;
		logic [6:0] readback;
		logic [7:0] dir_merged;
		logic [7:0] latch_merged;
		access = (read || write) && !ack_reg;
		dir_merged = merge_byte(dir_reg, writedata[7:0], byteenable[0]);
		latch_merged = merge_byte(latch_reg, writedata[7:0], byteenable[0]);
		latch_next = latch_reg;
		dir_next = dir_reg;
		ctl_next = ctl_reg;
		readdata_next = readdata_reg;
		ack_next = access;
		readback = (pin_in & ~dir_reg[6:0]) | (latch_reg[6:0] & dir_reg[6:0]);
		if (access && write)
		begin
			unique case (address)
				OFS_DIRECTION:
					dir_next = {1'b1, dir_merged[6:0]};
				OFS_LATCH:
					latch_next = {1'b1, latch_merged[6:0]};
				OFS_CONTROL:
				begin
					ctl_next[7:0] = merge_byte(ctl_reg[7:0], writedata[7:0], byteenable[0]);
					ctl_next[15:8] = merge_byte(ctl_reg[15:8], writedata[15:8], byteenable[1]);
				end
				default:
					ctl_next = ctl_reg;
			endcase
		end
		if (access && read)
		begin
			unique case (address)
				OFS_DIRECTION: readdata_next = {24'h000000, DIRECTION_READ};
				OFS_LATCH: readdata_next = {24'h000000, 1'b1, readback};
				OFS_CONTROL: readdata_next = {16'h0000, ctl_reg};
				OFS_STATUS: readdata_next = {17'h00000, function_owned, 1'b0, pin_in};
				default: readdata_next = UNMAPPED_READ;
			endcase
		end
		if (hw_standby)
		begin
			latch_next = LATCH_RESET;
			dir_next = DIRECTION_RESET;
		end
		// Software standby leaves latch and direction untouched
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			latch_reg <= LATCH_RESET;
			dir_reg <= DIRECTION_RESET;
			ctl_reg <= CONTROL_RESET;
			readdata_reg <= UNMAPPED_READ;
			ack_reg <= 1'b0;
		end
		else
		begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			ctl_reg <= ctl_next;
			readdata_reg <= readdata_next;
			ack_reg <= ack_next;
		end
	end

	assign waitrequest = (read || write) && !ack_reg;
	assign readdata = readdata_reg;

	// ****************************************************************
	// Pin multiplexing
	// ****************************************************************
	port_six_pin_mux u_mux
	(
		.expanded_mode(expanded_mode),
		.bus_release_enable(bus_release_enable),
		.wait_active(wait_active),
		.port_six_output_latch(latch_reg[6:0]),
		.port_six_direction_bits(dir_reg[6:0]),
		.ctl_out(ctl_out),
		.drive(drive),
		.function_owned(function_owned)
	);

	assign pin_out = drive.out;
	assign pin_oe_n = drive.oe_n;

	// Inactive (high) when the pin is not assigned to its function
	always_comb
	begin
		ctl_in.bus_release_request_n = function_owned[PIN_BUS_RELEASE_REQUEST] ? pin_in[PIN_BUS_RELEASE_REQUEST] : 1'b1;
		ctl_in.wait_n = function_owned[PIN_WAIT] ? pin_in[PIN_WAIT] : 1'b1;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_latch_bit_seven: assert property (@(posedge clk) disable iff (rst)
		latch_reg[7] && dir_reg[7]) else $error("reserved bit 7 not one");
	a_latch_readback: assert property (@(posedge clk) disable iff (rst)
		(read && !waitrequest && address == OFS_LATCH && $past(dir_reg) == dir_reg)
		|-> readdata[6:0] == (($past(pin_in) & ~dir_reg[6:0]) | (latch_reg[6:0] & dir_reg[6:0])))
		else $error("latch readback mismatch");
	a_dir_read_ones: assert property (@(posedge clk) disable iff (rst)
		(read && !waitrequest && address == OFS_DIRECTION) |-> readdata[7:0] == DIRECTION_READ)
		else $error("direction read not all ones");
	a_hw_standby_load: assert property (@(posedge clk) disable iff (rst)
		hw_standby |=> latch_reg == LATCH_RESET && dir_reg == DIRECTION_RESET)
		else $error("standby did not load reset values");
	a_sw_standby_hold: assert property (@(posedge clk) disable iff (rst)
		(power_mode == MODE_SW_STANDBY && !write) |=> $stable(latch_reg) && $stable(dir_reg))
		else $error("software standby changed registers");
	a_strobe_route: assert property (@(posedge clk) disable iff (rst)
		expanded_mode |-> pin_out[PIN_ADDR] == ctl_out.address_strobe_n && !pin_oe_n[PIN_LOW]
		&& pin_out[PIN_LOW] == ctl_out.low_byte_write_strobe_n)
		else $error("strobe not routed");
	a_back_route: assert property (@(posedge clk) disable iff (rst)
		(expanded_mode && bus_release_enable) |-> !pin_oe_n[PIN_BACK]
		&& pin_out[PIN_BACK] == ctl_out.bus_release_ack_n && pin_oe_n[PIN_BUS_RELEASE_REQUEST])
		else $error("bus release pins wrong");
	a_single_chip_io: assert property (@(posedge clk) disable iff (rst)
		!expanded_mode |-> pin_oe_n == ~dir_reg[6:0] && pin_out == latch_reg[6:0])
		else $error("single-chip pins not general I/O");
	a_wait_input: assert property (@(posedge clk) disable iff (rst)
		(expanded_mode && wait_active) |-> pin_oe_n[PIN_WAIT] && ctl_in.wait_n == pin_in[PIN_WAIT])
		else $error("wait pin not an input");
	a_answer_time: assert property (@(posedge clk) disable iff (rst)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("slave answer late");

	c_latch_read: cover property (@(posedge clk) read && !waitrequest && address == OFS_LATCH);
	c_release_on: cover property (@(posedge clk) expanded_mode && bus_release_enable);
	c_wait_on: cover property (@(posedge clk) expanded_mode && wait_active);
	c_hw_standby: cover property (@(posedge clk) hw_standby);

endmodule

// *** bench/bus_side_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Far side of the port pins
// ****************************************************************
module bus_side_model
(
	// Device drive
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe_n,
	// Levels put on pins the device has released
	input wire logic [6:0] ext_level,
	// Resolved pin levels
	output logic [6:0] pin_in
);
	// Release request and wait come from outside whenever the device lets go
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// *** bench/bus_control_shared_port_tb.sv ***
`timescale 1ns/1ps
module bus_control_shared_port_tb;
	import port_six_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic expanded_mode = 1'b0;
	power_mode_t power_mode = MODE_RUN;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	bus_ctl_out_t ctl_out = '1;
	bus_ctl_in_t ctl_in;
	logic [6:0] pin_in, pin_out, pin_oe_n;
	logic [6:0] ext_level = 7'h55;
	logic [31:0] seed = 32'h40;
	logic [31:0] exp_q[$];
	logic [7:0] val;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;

	initial forever #25 clk = ~clk;

	port_six i_port_six
	(
		.clk(clk), .rst(rst), .expanded_mode(expanded_mode), .power_mode(power_mode),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.ctl_out(ctl_out), .ctl_in(ctl_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n)
	);

	bus_side_model i_bus_side_model
	(
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checked++;
		if (seen !== expv)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic stop_test;
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Starts right after a rising edge; holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do @(negedge clk); while (waitrequest !== 1'b0);
		@(posedge clk);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] expv);
		exp_q.push_back({24'h0, expv});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic pins(input logic [6:0] mask, input logic [6:0] eo, input logic [6:0] eoe);
		@(negedge clk);
		check({25'h0, pin_out & mask}, {25'h0, eo & mask});
		check({25'h0, pin_oe_n}, {25'h0, eoe});
		@(posedge clk);
	endtask

	// ****************************************************************
	// Read data monitor and timeout
	// ****************************************************************
	always @(negedge clk)
		if (read === 1'b1 && waitrequest === 1'b0)
			check(readdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdeadbeef);

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			stop_test;
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_LATCH, {1'b1, ext_level});
		rd(OFS_DIRECTION, DIRECTION_READ);
		pins(7'h00, 7'h00, 7'h7f);
		seed = xorshift(seed);
		val = seed[7:0];
		bus(1'b1, OFS_DIRECTION, 32'h7f);
		bus(1'b1, OFS_LATCH, {24'h0, ~val});
		bus(1'b1, OFS_LATCH, {24'h0, val});
		rd(OFS_LATCH, {1'b1, val[6:0]});
		pins(7'h7f, val[6:0], 7'h00);
		expanded_mode <= 1'b1;
		ctl_out <= bus_ctl_out_t'(seed[12:8]);
		pins(7'h7f, {seed[12:9], val[2:0]}, 7'h00);
		check({30'h0, ctl_in}, 32'h3);
		power_mode <= MODE_SW_STANDBY;
		rd(OFS_LATCH, {1'b1, val[6:0]});
		power_mode <= MODE_HW_STANDBY;
		@(posedge clk);
		power_mode <= MODE_RUN;
		@(posedge clk);
		rd(OFS_LATCH, {1'b1, ctl_out[4:1], ext_level[2:0]});
		pins(7'h78, {ctl_out[4:1], 3'h0}, 7'h07);
		for (int i = 0; i < 2; i++)
		begin
			seed = xorshift(seed);
			ext_level <= seed[6:0];
			ctl_out <= bus_ctl_out_t'(seed[11:7]);
			bus(1'b1, OFS_CONTROL, i > 0 ? 32'h0001 : 32'hff03);
			@(negedge clk);
			check({30'h0, ctl_in}, {30'h0, ext_level[1:0]});
			pins(7'h7c, {ctl_out, 2'b00}, 7'h03);
		end
		stop_test;
	end
endmodule
